// [verilog/pcs_consts.svh]
// Offsets, field positions, codes and reset values for the power/stream command block
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_CMD_PWR_QUERY     8'he5
`define PCS_CMD_PWR_QUERY_ALT 8'h98
`define PCS_CMD_STREAM_CFG    8'h51
`define PCS_DEVHEAD_PWR_MASK  8'ha0
`define PCS_DEVHEAD_STR_MASK  8'he0
`define PCS_FEAT_ADD_BIT      7
`define PCS_FEAT_DIR_BIT      6
`define PCS_ERR_ABORT_BIT     2
`define PCS_ST_BUSY_BIT       7
`define PCS_ST_READY_BIT      6
`define PCS_ST_SEEK_BIT       4
`define PCS_ST_ERR_BIT        0
`define PCS_PWR_LOW_ANSWER    8'h00
`define PCS_PWR_UP_ANSWER     8'hff
`define PCS_REG_ERROR         4'h0
`define PCS_REG_STATUS        4'h1
`define PCS_REG_SECCNT        4'h2
`define PCS_REG_CTRL          4'h3
`define PCS_REG_IRQ_STAT      4'h4
`define PCS_REG_IRQ_MASK      4'h5
`define PCS_REG_SLOT_SEL      4'h6
`define PCS_REG_SLOT_INFO     4'h7
`define PCS_REG_SLOT_ALLOC    4'h8
`define PCS_REG_VALID_MAP     4'h9
`define PCS_CTRL_RESET        8'h01
`define PCS_IRQ_DONE_BIT      0
`define PCS_IRQ_ABORT_BIT     1
`endif

// [verilog/pcs_pkg.sv]
// Types shared by the power/stream command block
package pcs_pkg;
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] dev_head;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
  } pcs_taskfile_s;

  typedef struct packed {
    logic        valid;
    logic        write_dir;
    logic [7:0]  time_limit;
    logic [15:0] alloc_size;
  } pcs_slot_s;

  typedef enum logic [1:0] {
    PCS_IDLE  = 2'b00,
    PCS_EXEC  = 2'b01,
    PCS_DONE  = 2'b11
  } pcs_state_e;
endpackage

// [verilog/pcs_slot_table.sv]
// Eight-entry stream parameter table with one write port and two read ports
module pcs_slot_table
  import pcs_pkg::*;
#(
  parameter int SLOTS = 8
)(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Update port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(SLOTS)-1:0] wr_slot,
  input  wire pcs_slot_s                wr_entry,
  // Lookup ports
  input  wire logic [$clog2(SLOTS)-1:0] rd_slot_a,
  output pcs_slot_s                     rd_entry_a,
  input  wire logic [$clog2(SLOTS)-1:0] rd_slot_b,
  output pcs_slot_s                     rd_entry_b,
  output logic [SLOTS-1:0]              valid_map
);
  pcs_slot_s table_q [SLOTS];

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < SLOTS; i++)
        table_q[i] <= '0;
    end
    else if (wr_en)
      table_q[wr_slot] <= wr_entry;
  end

  assign rd_entry_a = table_q[rd_slot_a];
  assign rd_entry_b = table_q[rd_slot_b];

  always_comb
  begin
    for (int i = 0; i < SLOTS; i++)
      valid_map[i] = table_q[i].valid;
  end
endmodule

// [verilog/pcs_irq_flag.sv]
// One sticky interrupt flag, set by hardware, cleared by writing a one
module pcs_irq_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Event and software clear
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  // Flag
  output logic      flag_q
);
  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clock)
  begin
    if (!resetn)
      flag_q <= 1'b0;
    else if (set_pulse)
      flag_q <= 1'b1;
    else if (clear_pulse)
      flag_q <= 1'b0;
  end
endmodule

// [verilog/pcs_cmd_engine.sv]
// Power mode query and stream configuration command interpreter
// Operation
// R1 - Power query decoded from either of two codes, device/head bits 7 and 5 set.
// R2 - Power query tells whether spindle is up and media immediately reachable.
// R3 - Standby or sleep at query time returns zero in sector count.
// R4 - Any other power state returns all ones in sector count.
// R5 - Stream configuration decoded from its code, device/head bits 7, 6, 5 set.
// R6 - Each stream configuration command acts on exactly one stream.
// R7 - Add of an already valid slot overwrites its parameters unless aborted.
// R8 - Aborted stream configuration leaves the named slot unchanged.
// R9 - Abort sets error bit 2 only; all other error bits zero.
// R10 - Without streaming support every stream configuration command aborts.
// R11 - Remove of a never-established slot aborts.
// R12 - Feature bit 7 selects add (one) or remove (zero).
// R13 - Feature bit 6 selects read stream (zero) or write stream (one).
// R14 - Feature bits 2..0 carry the slot number, zero to seven.
// R15 - Allocation size is 16 bits: low byte current count, high byte previous.
// R16 - Eight-entry table holds valid, direction, time limit, allocation size.
// R17 - Completion clears busy, sets ready, error only on abort, then interrupts.
`include "pcs_consts.svh"
module pcs_cmd_engine
  import pcs_pkg::*;
#(
  parameter int    SLOTS         = 8,
  parameter bit    STREAM_SUPPORT = 1'b1
)(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // Task file from the host side
  input  wire pcs_taskfile_s taskfile,
  input  wire logic          cmd_write,
  // Drive state
  input  wire logic          spindle_low_power,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic [7:0]         reg_rdata,
  // Answer to the host side
  output logic [7:0]         error_out,
  output logic [7:0]         status_out,
  output logic [7:0]         sector_count_out,
  output logic               cmd_done,
  output logic               irq
);
  localparam int SW = $clog2(SLOTS);

  pcs_state_e    state_q;
  pcs_taskfile_s tf_q;
  logic [7:0]    err_q;
  logic [7:0]    status_q;
  logic [7:0]    seccnt_q;
  logic [7:0]    ctrl_q;
  logic [1:0]    irq_mask_q;
  logic [SW-1:0] sel_q;
  logic [7:0]    rdata_q;
  logic          done_q;

  logic          is_pwr;
  logic          is_str;
  logic          do_abort;
  logic          tbl_wr;
  pcs_slot_s     new_entry;
  pcs_slot_s     cur_entry;
  pcs_slot_s     sel_entry;
  logic [SLOTS-1:0] valid_map;
  logic [SW-1:0] cmd_slot;
  logic [1:0]    irq_flags;
  logic [1:0]    irq_clr;
  logic          finish;

  // Decode from the latched task file
  assign is_pwr = ((tf_q.command == `PCS_CMD_PWR_QUERY) ||
                   (tf_q.command == `PCS_CMD_PWR_QUERY_ALT)) &&
                  ((tf_q.dev_head & `PCS_DEVHEAD_PWR_MASK) == `PCS_DEVHEAD_PWR_MASK); // see R1
  assign is_str = (tf_q.command == `PCS_CMD_STREAM_CFG) &&
                  ((tf_q.dev_head & `PCS_DEVHEAD_STR_MASK) == `PCS_DEVHEAD_STR_MASK); // see R5

  assign cmd_slot = tf_q.feat_cur[SW-1:0]; // see R14

  // Software may turn streaming off through the control register
  always_comb
  begin
    do_abort = 1'b0;
    if (!is_str)
      do_abort = !is_pwr;
    else if (!STREAM_SUPPORT || !ctrl_q[0])
      do_abort = 1'b1; // see R10
    else if (!tf_q.feat_cur[`PCS_FEAT_ADD_BIT] && !cur_entry.valid)
      do_abort = 1'b1; // see R11
  end

  always_comb
  begin
    new_entry            = '0;
    new_entry.valid      = tf_q.feat_cur[`PCS_FEAT_ADD_BIT]; // see R12
    new_entry.write_dir  = tf_q.feat_cur[`PCS_FEAT_DIR_BIT]; // see R13
    new_entry.time_limit = tf_q.feat_prev;
    new_entry.alloc_size = {tf_q.cnt_prev, tf_q.cnt_cur}; // see R15
  end

  // Only one slot is written per command, and never on abort
  assign finish = (state_q == PCS_EXEC);
  assign tbl_wr = finish && is_str && !do_abort; // see R6, R7, R8

  pcs_slot_table #(
    .SLOTS (SLOTS)
  ) u_table (
    .clock      (clock),
    .resetn     (resetn),
    .wr_en      (tbl_wr),
    .wr_slot    (cmd_slot),
    .wr_entry   (new_entry), // see R16
    .rd_slot_a  (cmd_slot),
    .rd_entry_a (cur_entry),
    .rd_slot_b  (sel_q),
    .rd_entry_b (sel_entry),
    .valid_map  (valid_map)
  );

  // Command sequencing: latch, execute one cycle, then done
  always_ff @(posedge clock)
  begin
    if (!resetn)
      state_q <= PCS_IDLE;
    else
    begin
      case (state_q)
        PCS_IDLE: if (cmd_write) state_q <= PCS_EXEC;
        PCS_EXEC: state_q <= PCS_DONE;
        PCS_DONE: state_q <= PCS_IDLE;
        default:  state_q <= PCS_IDLE;
      endcase
    end
  end

  // Commands arriving while busy are ignored
  always_ff @(posedge clock)
  begin
    if (!resetn)
      tf_q <= '0;
    else if (cmd_write && state_q == PCS_IDLE)
      tf_q <= taskfile;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      seccnt_q <= '0;
    else if (finish && is_pwr)
      seccnt_q <= spindle_low_power ? `PCS_PWR_LOW_ANSWER   // see R3
                                    : `PCS_PWR_UP_ANSWER;   // see R2, R4
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      err_q <= '0;
    else if (finish)
    begin
      err_q                     <= '0;
      err_q[`PCS_ERR_ABORT_BIT] <= do_abort; // see R9
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      status_q                   <= '0;
      status_q[`PCS_ST_READY_BIT] <= 1'b1;
    end
    else if (cmd_write && state_q == PCS_IDLE)
    begin
      status_q                   <= '0;
      status_q[`PCS_ST_BUSY_BIT] <= 1'b1;
    end
    else if (finish)
    begin
      status_q                    <= '0;
      status_q[`PCS_ST_READY_BIT] <= 1'b1; // see R17
      status_q[`PCS_ST_SEEK_BIT]  <= is_str;
      status_q[`PCS_ST_ERR_BIT]   <= do_abort; // see R17
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else
      done_q <= finish; // see R17
  end

  // Software control registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
      ctrl_q <= `PCS_CTRL_RESET;
    else if (reg_write && reg_addr == `PCS_REG_CTRL)
      ctrl_q <= reg_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      irq_mask_q <= '0;
    else if (reg_write && reg_addr == `PCS_REG_IRQ_MASK)
      irq_mask_q <= reg_wdata[1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      sel_q <= '0;
    else if (reg_write && reg_addr == `PCS_REG_SLOT_SEL)
      sel_q <= reg_wdata[SW-1:0];
  end

  assign irq_clr = (reg_write && reg_addr == `PCS_REG_IRQ_STAT) ? reg_wdata[1:0] : 2'b00;

  pcs_irq_flag u_irq_done (
    .clock       (clock),
    .resetn      (resetn),
    .set_pulse   (finish),
    .clear_pulse (irq_clr[`PCS_IRQ_DONE_BIT]),
    .flag_q      (irq_flags[`PCS_IRQ_DONE_BIT])
  );

  pcs_irq_flag u_irq_abort (
    .clock       (clock),
    .resetn      (resetn),
    .set_pulse   (finish && do_abort),
    .clear_pulse (irq_clr[`PCS_IRQ_ABORT_BIT]),
    .flag_q      (irq_flags[`PCS_IRQ_ABORT_BIT])
  );

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!resetn)
      rdata_q <= '0;
    else if (reg_read)
    begin
      case (reg_addr)
        `PCS_REG_ERROR:      rdata_q <= err_q;
        `PCS_REG_STATUS:     rdata_q <= status_q;
        `PCS_REG_SECCNT:     rdata_q <= seccnt_q;
        `PCS_REG_CTRL:       rdata_q <= ctrl_q;
        `PCS_REG_IRQ_STAT:   rdata_q <= {6'h00, irq_flags};
        `PCS_REG_IRQ_MASK:   rdata_q <= {6'h00, irq_mask_q};
        `PCS_REG_SLOT_SEL:   rdata_q <= 8'(sel_q);
        `PCS_REG_SLOT_INFO:  rdata_q <= {sel_entry.valid, sel_entry.write_dir, 6'h00};
        `PCS_REG_SLOT_ALLOC: rdata_q <= sel_entry.alloc_size[7:0];
        `PCS_REG_VALID_MAP:  rdata_q <= 8'(valid_map);
        default:             rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata        = rdata_q;
  assign error_out        = err_q;
  assign status_out       = status_q;
  assign sector_count_out = seccnt_q;
  assign cmd_done         = done_q;
  assign irq              = |(irq_flags & irq_mask_q);
endmodule

// [sim/pcs_cmd_props.sv]
// Checker for the power/stream command block ports
module pcs_cmd_props
  import pcs_pkg::*;
#(
  parameter int SLOTS          = 8,
  parameter bit STREAM_SUPPORT = 1'b1
)(
  // Clock and reset
  input wire logic          clock,
  input wire logic          resetn,
  // Command side
  input wire pcs_taskfile_s taskfile,
  input wire logic          cmd_write,
  input wire logic          spindle_low_power,
  // Register port
  input wire logic [3:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_write,
  input wire logic          reg_read,
  input wire logic [7:0]    reg_rdata,
  // Answers
  input wire logic [7:0]    error_out,
  input wire logic [7:0]    status_out,
  input wire logic [7:0]    sector_count_out,
  input wire logic          cmd_done,
  input wire logic          irq
);
  logic pwr_go;
  assign pwr_go = cmd_write && ((taskfile.dev_head & 8'ha0) == 8'ha0)
                  && (taskfile.command == 8'he5 || taskfile.command == 8'h98);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_done_cause: assert property (cmd_done |-> $past(cmd_write, 2))
    else $error("done without a command two cycles before");
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done longer than one cycle");
  a_done_ready: assert property (cmd_done |-> status_out[7:6] == 2'b01)
    else $error("busy or not ready at completion");
  a_err_flag: assert property (cmd_done |-> status_out[0] == error_out[2])
    else $error("status error flag differs from abort bit");
  a_abort_only: assert property ((error_out & 8'hfb) == 8'h00)
    else $error("error bit other than abort set");
  a_pwr_answer: assert property (cmd_done && $past(pwr_go, 2) |->
    sector_count_out == ($past(spindle_low_power) ? 8'h00 : 8'hff)
    && error_out == 8'h00)
    else $error("power query answer wrong");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  a_read_stat: assert property ($past(reg_read && reg_addr == 4'h1) |->
    reg_rdata == $past(status_out))
    else $error("status read back wrong");
endmodule

bind pcs_cmd_engine pcs_cmd_props #(.SLOTS(SLOTS), .STREAM_SUPPORT(STREAM_SUPPORT)) u_props (
  .clock(clock), .resetn(resetn), .taskfile(taskfile), .cmd_write(cmd_write),
  .spindle_low_power(spindle_low_power), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .error_out(error_out),
  .status_out(status_out), .sector_count_out(sector_count_out), .cmd_done(cmd_done),
  .irq(irq));

// [sim/pcs_host_model.sv]
// Host adapter model that writes task-file commands
`include "pcs_consts.svh"
module pcs_host_model
  import pcs_pkg::*;
(
  // Clock
  input wire logic clock,
  // Task file toward the drive
  output pcs_taskfile_s taskfile,
  output logic          cmd_write
);
  initial
  begin
    taskfile  = '0;
    cmd_write = 1'b0;
  end
  task automatic send(input pcs_taskfile_s t);
    @(posedge clock);
    taskfile  <= t;
    cmd_write <= 1'b1;
    @(posedge clock);
    cmd_write <= 1'b0;
    // Lines no longer qualified show the inverse, not a held copy
    taskfile  <= ~t;
  endtask
  task automatic pwr(input logic [7:0] code);
    pcs_taskfile_s t;
    t = '0;
    t.command  = code;
    t.dev_head = `PCS_DEVHEAD_PWR_MASK;
    send(t);
  endtask
  task automatic cfg(input logic add, input logic wd, input logic [2:0] slot,
                     input logic [7:0] tl, input logic [15:0] alloc, input logic [7:0] dh);
    pcs_taskfile_s t;
    t = '0;
    t.command  = `PCS_CMD_STREAM_CFG;
    t.dev_head = dh;
    t.feat_cur = {add, wd, 3'h0, slot};
    t.feat_prev = tl;
    {t.cnt_prev, t.cnt_cur} = alloc;
    send(t);
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the power/stream command block
`include "pcs_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock, resetn, spindle_low_power, cmd_write;
  logic          reg_write, reg_read, cmd_done, irq;
  logic [3:0]    reg_addr;
  logic [7:0]    reg_wdata, reg_rdata, error_out, status_out, sector_count_out;
  pcs_taskfile_s taskfile;
  int            error_cnt, samples_checked;
  always #12.5 clock = ~clock;
  pcs_host_model host (.clock(clock), .taskfile(taskfile), .cmd_write(cmd_write));
  pcs_cmd_engine dut (.clock(clock), .resetn(resetn), .taskfile(taskfile),
    .cmd_write(cmd_write), .spindle_low_power(spindle_low_power), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .error_out(error_out), .status_out(status_out),
    .sector_count_out(sector_count_out), .cmd_done(cmd_done), .irq(irq));
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Bit 4 is left out of the status compare: its value is not fixed here
  task automatic done_chk(input logic [7:0] st, input logic [7:0] er);
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < 8)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (cmd_done !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
    else
    begin
      `CHK(status_out & 8'hef, st)
      `CHK(error_out, er)
      @(posedge clock);
    end
  endtask
  initial
  begin
    clock = 1'b0;
    resetn = 1'b0;
    spindle_low_power = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd(4'h1, 8'h40);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h01);
    rd(4'h5, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'hf, 8'h00);
    wr(4'h5, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      spindle_low_power <= i[0];
      host.pwr(i[1] ? 8'h98 : 8'he5);
      done_chk(8'h40, 8'h00);
      `CHK(sector_count_out, i[0] ? 8'h00 : 8'hff)
    end
    host.cfg(1'b0, 1'b0, 3'h3, 8'h00, 16'h0000, 8'he0);
    done_chk(8'h41, 8'h04);
    `CHK(irq, 1'b1)
    rd(4'h4, 8'h03);
    wr(4'h4, 8'h03);
    rd(4'h4, 8'h00);
    `CHK(irq, 1'b0)
    host.cfg(1'b1, 1'b1, 3'h3, 8'h11, 16'h1234, 8'he0);
    done_chk(8'h40, 8'h00);
    wr(4'h6, 8'h03);
    rd(4'h7, 8'hc0);
    rd(4'h8, 8'h34);
    rd(4'h9, 8'h08);
    host.cfg(1'b1, 1'b0, 3'h3, 8'h22, 16'h0056, 8'he0);
    done_chk(8'h40, 8'h00);
    rd(4'h7, 8'h80);
    rd(4'h8, 8'h56);
    host.cfg(1'b1, 1'b1, 3'h3, 8'h33, 16'h0099, 8'ha0);
    done_chk(8'h41, 8'h04);
    rd(4'h7, 8'h80);
    rd(4'h8, 8'h56);
    host.cfg(1'b0, 1'b0, 3'h3, 8'h00, 16'h0000, 8'he0);
    done_chk(8'h40, 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h3, 8'h00);
    host.cfg(1'b1, 1'b0, 3'h7, 8'h00, 16'h0001, 8'he0);
    done_chk(8'h41, 8'h04);
    rd(4'h9, 8'h00);
    stop_test();
  end
endmodule
